// file: hw/sfpe_consts.svh
/*
  Shared constants of the serial flash program/erase sequencer: opcodes,
  erase size codes, field positions and self-timed operation times.
  Assumes a 125 MHz reference clock on the device and host side.
*/
`ifndef SFPE_CONSTS_SVH
`define SFPE_CONSTS_SVH

// Opcodes
`define SFPE_OP_WR_EN        8'h06
`define SFPE_OP_WR_DIS       8'h04
`define SFPE_OP_PROG         8'h02
`define SFPE_OP_PROG_DUAL    8'hA2
`define SFPE_OP_ERASE_4K     8'h20
`define SFPE_OP_ERASE_32K    8'h52
`define SFPE_OP_ERASE_64K    8'hD8

// Erase size codes and ignored low address bits
`define SFPE_ESZ_4K          2'h0
`define SFPE_ESZ_32K         2'h1
`define SFPE_ESZ_64K         2'h2
`define SFPE_MASK_4K         24'hFFF000
`define SFPE_MASK_32K        24'hFF8000
`define SFPE_MASK_64K        24'hFF0000

// Frame layout: opcode plus three address bytes
`define SFPE_HDR_BYTES       3'h4
`define SFPE_PAGE_BYTES      9'h100
`define SFPE_SECTOR_MSB      20
`define SFPE_SECTOR_LSB      16
`define SFPE_ERASED_BYTE     8'hFF

// Operation times in ns (plain defaults) and the clock period
`define SFPE_REF_CLK_NS              8
`define SFPE_BYTE_PROGRAM_TIME_NS    20000
`define SFPE_PAGE_PROGRAM_TIME_NS    200000
`define SFPE_BLOCK_ERASE_TIME_NS     1000000
`define SFPE_BYTE_PROG_CYC  (`SFPE_BYTE_PROGRAM_TIME_NS / `SFPE_REF_CLK_NS)
`define SFPE_PAGE_PROG_CYC  (`SFPE_PAGE_PROGRAM_TIME_NS / `SFPE_REF_CLK_NS)
`define SFPE_ERASE_CYC      (`SFPE_BLOCK_ERASE_TIME_NS / `SFPE_REF_CLK_NS)

`endif

// file: hw/sfpe_pkg.sv
/*
  Types and opcode decoders of the serial flash program/erase sequencer.
  Assumes sfpe_consts.svh is on the include path.
*/
`include "sfpe_consts.svh"

package sfpe_pkg;

  // Device sequencer states
  typedef enum logic [2:0]
  {
    SFPE_S_IDLE  = 3'b001,
    SFPE_S_PROG  = 3'b010,
    SFPE_S_ERASE = 3'b100
  } sfpe_seq_e;

  // Host frame states
  typedef enum logic [2:0]
  {
    SFPE_H_IDLE  = 3'b001,
    SFPE_H_SHIFT = 3'b010,
    SFPE_H_GAP   = 3'b100
  } sfpe_host_e;

  // Either program opcode
  function automatic logic sfpe_is_prog(input logic [7:0] op);
    return (op == `SFPE_OP_PROG) || (op == `SFPE_OP_PROG_DUAL);
  endfunction : sfpe_is_prog

  // Any block erase opcode
  function automatic logic sfpe_is_erase(input logic [7:0] op);
    return (op == `SFPE_OP_ERASE_4K) || (op == `SFPE_OP_ERASE_32K)
        || (op == `SFPE_OP_ERASE_64K);
  endfunction : sfpe_is_erase

  // Address bits kept for a block erase
  function automatic logic [23:0] sfpe_erase_mask(input logic [7:0] op);
    case (op)
      `SFPE_OP_ERASE_4K:  return `SFPE_MASK_4K;
      `SFPE_OP_ERASE_32K: return `SFPE_MASK_32K;
      default:            return `SFPE_MASK_64K;
    endcase
  endfunction : sfpe_erase_mask

endpackage : sfpe_pkg

// file: hw/sfpe_link_if.sv
/*
  Serial link between the host and the flash device: chip select, clock,
  serial input and one two-way data pin. Resolves the two-way pin from the
  drivers' enables; an undriven pin reads high as if pulled up.
*/
`timescale 1ns/10ps

interface sfpe_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic bio_h;
  logic bio_h_oe;
  logic bio_d;
  logic bio_d_oe;
  logic bio;

  // Resolved level of the two-way pin
  assign bio = bio_h_oe ? bio_h : (bio_d_oe ? bio_d : 1'b1);

  modport host (output sck, output cs_n, output si, output bio_h, output bio_h_oe,
                input bio);
  modport dev  (input sck, input cs_n, input si, input bio,
                output bio_d, output bio_d_oe);
endinterface : sfpe_link_if

// file: hw/sfpe_dev.sv
/*
  Flash device end: shifts in program and erase frames on the link clock,
  buffers one page, then runs self-timed program or erase on ref_clk_i.
  Assumes the host keeps the link clock still while chip select is high and
  waits for busy_o low before the next command.
*/
`timescale 1ns/10ps

// Functional notes
// R1 - Program needs write enable latch set
// R2 - Opcode 02h, three address bytes, buffered data
// R3 - Unaligned data wraps within same page
// R4 - Over 256 bytes keeps last 256
// R5 - Program at release, unsent bytes stay erased
// R6 - Incomplete address, data or byte aborts
// R7 - Protected sector program skipped, back idle
// R8 - Program abort clears write enable latch
// R9 - Busy during programming, host polls
// R10 - Latch cleared before program completes
// R11 - Program failure sets error flag
// R12 - Opcode A2h takes data two bits wide
// R13 - Dual bits seven/six first, byte per four
// R14 - Opcodes 20h/52h/D8h erase 4/32/64 kB
// R15 - Erase needs write enable latch set
// R16 - Extra bytes ignored, erase at release
// R17 - Erase ignores low address bits
// R18 - Incomplete address or byte aborts erase
// R19 - Protected sector erase skipped, back idle
// R20 - Erase abort clears write enable latch
// R21 - Erase busy, latch cleared, failure flagged
// R22 - Ready again after finish or abort
module sfpe_dev
  import sfpe_pkg::*;
#(
  parameter int BYTE_PROG_CYC = `SFPE_BYTE_PROG_CYC,
  parameter int PAGE_PROG_CYC = `SFPE_PAGE_PROG_CYC,
  parameter int ERASE_CYC     = `SFPE_ERASE_CYC
)
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Serial link
  sfpe_link_if.dev         link,
  // Array status inputs
  input  wire logic [31:0] prot_i,
  input  wire logic        fail_i,
  // Status
  output logic             busy_o,
  output logic             wel_o,
  output logic             err_o,
  // Array program port
  output logic             mem_we_o,
  output logic [23:0]      mem_addr_o,
  output logic [7:0]       mem_data_o,
  // Array erase port
  output logic             erase_req_o,
  output logic [23:0]      erase_addr_o,
  output logic [1:0]       erase_size_o
);

  // Link clock domain
  logic        started_reg;
  logic [2:0]  bib_reg;
  logic [2:0]  bib_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [2:0]  hdr_reg;
  logic [2:0]  hdr_cur;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [8:0]  dcnt_reg;
  logic [7:0]  wptr_reg;
  logic        aligned_reg;
  logic        ftog_reg;
  logic        dual_ph;
  logic        byte_done;
  logic [7:0]  buf_mem [0:255];

  // Reference clock domain
  logic        lrst_reg;
  logic        cs_s1_reg;
  logic        cs_s2_reg;
  logic        cs_d_reg;
  logic        tg_s1_reg;
  logic        tg_s2_reg;
  logic        seen_reg;
  logic        frame_end;
  logic        hdr_ok;
  logic        prot_hit;
  sfpe_seq_e   state_reg;
  logic [23:0] timer_reg;
  logic [8:0]  idx_reg;
  logic [8:0]  cnt_reg;
  logic [7:0]  pofs;

  // Bit steering; dual width only in the data phase of A2h
  always_comb
  begin
    hdr_cur   = started_reg ? hdr_reg : 3'h0;
    dual_ph   = (hdr_cur == `SFPE_HDR_BYTES) && (op_reg == `SFPE_OP_PROG_DUAL); // R12
    bib_next  = bib_reg + (dual_ph ? 3'h2 : 3'h1);                               // R13
    sh_next   = dual_ph ? {sh_reg[5:0], link.bio, link.si} : {sh_reg[6:0], link.si}; // R13
    byte_done = (bib_next == 3'h0);
  end

  // Bit position restarts with every frame
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      started_reg <= 1'b0;
      bib_reg     <= 3'h0;
    end
    else
    begin
      started_reg <= 1'b1;
      bib_reg     <= bib_next;
    end
  end

  // Frame marker; reset only while the host is in reset too
  always_ff @(posedge link.sck or posedge lrst_reg)
  begin
    if (lrst_reg)
      ftog_reg <= 1'b0;
    else if (!started_reg)
      ftog_reg <= ~ftog_reg;
  end

  // Frame contents; kept after release so the sequencer can read them
  always_ff @(posedge link.sck)
  begin
    sh_reg      <= sh_next;
    aligned_reg <= byte_done;                                  // R6 R18
    hdr_reg     <= hdr_cur;
    if (!started_reg)
      dcnt_reg <= 9'h000;
    if (byte_done)
    begin
      if (hdr_cur == 3'h0)
        op_reg <= sh_next;                                     // R2 R12 R14
      if ((hdr_cur != 3'h0) && (hdr_cur != `SFPE_HDR_BYTES))
        addr_reg <= {addr_reg[15:0], sh_next};                 // R2
      if (hdr_cur != `SFPE_HDR_BYTES)
        hdr_reg <= hdr_cur + 3'h1;
      if (hdr_cur == 3'h3)
        wptr_reg <= sh_next;                                   // R3
      else if ((hdr_cur == `SFPE_HDR_BYTES) && sfpe_is_prog(op_reg))
      begin
        // Page offset slots: wrap and overwrite keep the last 256 bytes
        buf_mem[wptr_reg] <= sh_next;                          // R3 R4
        wptr_reg          <= wptr_reg + 8'h01;                 // R3
        if (dcnt_reg != `SFPE_PAGE_BYTES)
          dcnt_reg <= (started_reg ? dcnt_reg : 9'h000) + 9'h001; // R4
      end
    end
  end

  // Two-way pin is input only for these commands
  always_ff @(posedge ref_clk_i)
  begin
    link.bio_d    <= 1'b0;
    link.bio_d_oe <= 1'b0;
  end

  // Reset mirror and synchronisers from the link side
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      lrst_reg  <= 1'b1;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg  <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      seen_reg  <= 1'b0;
    end
    else
    begin
      lrst_reg  <= 1'b0;
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg  <= cs_s2_reg;
      tg_s1_reg <= ftog_reg;
      tg_s2_reg <= tg_s1_reg;
      if (cs_s2_reg && !cs_d_reg)
        seen_reg <= tg_s2_reg;
    end
  end

  // Release of a frame that carried clocks; contents are static by now
  assign frame_end = cs_s2_reg && !cs_d_reg && (tg_s2_reg != seen_reg);
  assign hdr_ok    = (hdr_reg == `SFPE_HDR_BYTES) && aligned_reg;
  assign prot_hit  = prot_i[addr_reg[`SFPE_SECTOR_MSB:`SFPE_SECTOR_LSB]];
  assign pofs      = addr_reg[7:0] + idx_reg[7:0];

  // Command decode and self-timed sequencing
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= SFPE_S_IDLE;
      busy_o    <= 1'b0;
      wel_o     <= 1'b0;
      err_o     <= 1'b0;
      timer_reg <= 24'h000000;
      idx_reg   <= 9'h000;
      cnt_reg   <= 9'h000;
    end
    else
    begin
      case (state_reg)
        SFPE_S_IDLE:
        begin
          // Frames arriving while busy are dropped
          if (frame_end && (op_reg == `SFPE_OP_WR_EN) && (hdr_reg == 3'h1) && aligned_reg)
            wel_o <= 1'b1;
          else if (frame_end && (op_reg == `SFPE_OP_WR_DIS) && aligned_reg)
            wel_o <= 1'b0;
          else if (frame_end && sfpe_is_prog(op_reg) && wel_o)     // R1
          begin
            wel_o <= 1'b0;                                         // R8 R10
            if (hdr_ok && (dcnt_reg != 9'h000) && !prot_hit)       // R6 R7
            begin
              state_reg <= SFPE_S_PROG;                            // R5
              busy_o    <= 1'b1;                                   // R9
              err_o     <= 1'b0;
              idx_reg   <= 9'h000;
              cnt_reg   <= dcnt_reg;
              timer_reg <= (dcnt_reg == 9'h001) ? 24'(BYTE_PROG_CYC) : 24'(PAGE_PROG_CYC); // R5
            end
          end
          else if (frame_end && sfpe_is_erase(op_reg) && wel_o)    // R15
          begin
            wel_o <= 1'b0;                                         // R20 R21
            if (hdr_ok && !prot_hit)                               // R16 R18 R19
            begin
              state_reg <= SFPE_S_ERASE;
              busy_o    <= 1'b1;                                   // R21
              err_o     <= 1'b0;
              timer_reg <= 24'(ERASE_CYC);                         // R16
            end
          end
        end
        SFPE_S_PROG, SFPE_S_ERASE:
        begin
          if (fail_i)
            err_o <= 1'b1;                                         // R11 R21
          if (idx_reg != cnt_reg)
            idx_reg <= idx_reg + 9'h001;
          timer_reg <= timer_reg - 24'h000001;
          if (timer_reg <= 24'h000001)
          begin
            state_reg <= SFPE_S_IDLE;                              // R22
            busy_o    <= 1'b0;                                     // R22
          end
        end
        default:
        begin
          state_reg <= SFPE_S_IDLE;
          busy_o    <= 1'b0;
        end
      endcase
    end
  end

  // Array ports; only sent bytes are written, the rest stays erased
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      mem_we_o     <= 1'b0;
      mem_addr_o   <= 24'h000000;
      mem_data_o   <= `SFPE_ERASED_BYTE;
      erase_req_o  <= 1'b0;
      erase_addr_o <= 24'h000000;
      erase_size_o <= `SFPE_ESZ_4K;
    end
    else
    begin
      mem_we_o    <= (state_reg == SFPE_S_PROG) && (idx_reg != cnt_reg); // R5
      mem_addr_o  <= {addr_reg[23:8], pofs};                             // R3
      mem_data_o  <= buf_mem[pofs];
      erase_req_o <= frame_end && (state_reg == SFPE_S_IDLE) && sfpe_is_erase(op_reg)
                     && wel_o && hdr_ok && !prot_hit;                     // R14
      erase_addr_o <= addr_reg & sfpe_erase_mask(op_reg);                // R17
      case (op_reg)
        `SFPE_OP_ERASE_4K:  erase_size_o <= `SFPE_ESZ_4K;                // R14
        `SFPE_OP_ERASE_32K: erase_size_o <= `SFPE_ESZ_32K;
        default:            erase_size_o <= `SFPE_ESZ_64K;
      endcase
    end
  end

endmodule : sfpe_dev

// file: hw/sfpe_host.sv
/*
  Host end: frames one command on the link, mode 0, link clock at half the
  reference rate. Can send short address, any data count and stray tail
  bits so that abort cases can be produced. Assumes the data source holds
  the next byte on data_i before it is taken.
*/
`timescale 1ns/10ps

module sfpe_host
  import sfpe_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Serial link
  sfpe_link_if.host        link,
  // Command request
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_op_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [1:0]  cmd_addr_bytes_i,
  input  wire logic [9:0]  cmd_data_bytes_i,
  input  wire logic [2:0]  cmd_tail_bits_i,
  input  wire logic [7:0]  data_i,
  // Command status
  output logic             cmd_ready_o,
  output logic             data_take_o,
  output logic             done_o
);

  sfpe_host_e  state_reg;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [1:0]  aleft_reg;
  logic [1:0]  aidx_reg;
  logic [9:0]  dleft_reg;
  logic [2:0]  tleft_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  bits_reg;
  logic        dual_reg;
  logic [7:0]  ld_sh;
  logic [3:0]  ld_bits;
  logic        ld_dual;
  logic [1:0]  ld_sel;

  // Next unit: same byte, address byte, data byte, tail bits, or end
  always_comb
  begin
    ld_sh   = 8'h00;
    ld_bits = 4'h0;
    ld_dual = 1'b0;
    ld_sel  = 2'h0;
    if (bits_reg > 4'h1)
    begin
      ld_sh   = dual_reg ? {sh_reg[5:0], 2'h0} : {sh_reg[6:0], 1'b0};
      ld_bits = bits_reg - 4'h1;
      ld_dual = dual_reg;
    end
    else if (aleft_reg != 2'h0)
    begin
      ld_sh   = (aidx_reg == 2'h0) ? addr_reg[23:16] :
                (aidx_reg == 2'h1) ? addr_reg[15:8] : addr_reg[7:0];
      ld_bits = 4'h8;
      ld_sel  = 2'h1;
    end
    else if (dleft_reg != 10'h000)
    begin
      ld_sh   = data_i;
      ld_dual = (op_reg == `SFPE_OP_PROG_DUAL);
      ld_bits = ld_dual ? 4'h4 : 4'h8;
      ld_sel  = 2'h2;
    end
    else if (tleft_reg != 3'h0)
    begin
      ld_bits = {1'b0, tleft_reg};
      ld_sel  = 2'h3;
    end
  end

  // Frame sequencing; pins change while the clock is low
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg     <= SFPE_H_IDLE;
      link.sck      <= 1'b0;
      link.cs_n     <= 1'b1;
      link.si       <= 1'b0;
      link.bio_h    <= 1'b0;
      link.bio_h_oe <= 1'b0;
      cmd_ready_o   <= 1'b0;
      data_take_o   <= 1'b0;
      done_o        <= 1'b0;
      op_reg        <= 8'h00;
      addr_reg      <= 24'h000000;
      aleft_reg     <= 2'h0;
      aidx_reg      <= 2'h0;
      dleft_reg     <= 10'h000;
      tleft_reg     <= 3'h0;
      sh_reg        <= 8'h00;
      bits_reg      <= 4'h0;
      dual_reg      <= 1'b0;
    end
    else
    begin
      data_take_o <= 1'b0;
      done_o      <= 1'b0;
      case (state_reg)
        SFPE_H_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o <= 1'b0;
            state_reg   <= SFPE_H_SHIFT;
            op_reg      <= cmd_op_i;
            addr_reg    <= cmd_addr_i;
            aleft_reg   <= cmd_addr_bytes_i;
            aidx_reg    <= 2'h0;
            dleft_reg   <= cmd_data_bytes_i;
            tleft_reg   <= cmd_tail_bits_i;
            sh_reg      <= cmd_op_i;
            bits_reg    <= 4'h8;
            dual_reg    <= 1'b0;
            link.cs_n   <= 1'b0;
            link.si     <= cmd_op_i[7];
          end
        end
        SFPE_H_SHIFT:
        begin
          link.sck <= ~link.sck;
          if (link.sck && (ld_bits == 4'h0))
          begin
            link.cs_n     <= 1'b1;
            link.bio_h_oe <= 1'b0;
            state_reg     <= SFPE_H_GAP;
          end
          else if (link.sck)
          begin
            sh_reg        <= ld_sh;
            bits_reg      <= ld_bits;
            dual_reg      <= ld_dual;
            link.si       <= ld_dual ? ld_sh[6] : ld_sh[7];
            link.bio_h    <= ld_sh[7];
            link.bio_h_oe <= ld_dual;
            if (ld_sel == 2'h1)
            begin
              aleft_reg <= aleft_reg - 2'h1;
              aidx_reg  <= aidx_reg + 2'h1;
            end
            if (ld_sel == 2'h2)
            begin
              dleft_reg   <= dleft_reg - 10'h001;
              data_take_o <= 1'b1;
            end
            if (ld_sel == 2'h3)
              tleft_reg <= 3'h0;
          end
        end
        SFPE_H_GAP:
        begin
          // One idle cycle keeps chip select high between frames
          done_o    <= 1'b1;
          state_reg <= SFPE_H_IDLE;
        end
        default:
          state_reg <= SFPE_H_IDLE;
      endcase
    end
  end

endmodule : sfpe_host

// file: bench/sfpe_assertions.sv
/*
  Checker for the link and the device status of the program/erase sequencer.
  Assumes one reference clock and its synchronous active-low reset.
*/
`timescale 1ns/10ps

module sfpe_assertions
(
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  // Link
  input wire logic        cs_n,
  input wire logic        sck,
  // Device status and array ports
  input wire logic        busy_o,
  input wire logic        wel_o,
  input wire logic        err_o,
  input wire logic        fail_i,
  input wire logic        mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic        erase_req_o,
  input wire logic [23:0] erase_addr_o,
  input wire logic [1:0]  erase_size_o
);
  logic        cs_reg;
  logic        we_reg;
  logic [23:0] addr_reg;

  // Previous link and write state, kept apart so no assertion nests past()
  always_ff @(posedge ref_clk_i)
  begin
    cs_reg   <= cs_n;
    we_reg   <= mem_we_o;
    addr_reg <= mem_addr_o;
  end

  default clocking dck @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Start of a self-timed operation
  sequence s_start;
    $rose(busy_o);
  endsequence

  // Erase launched on the same edge as busy
  sequence s_erase_go;
    erase_req_o && $rose(busy_o);
  endsequence

  a_link_quiet: assert property (cs_n && cs_reg |-> !sck)
    else $error("link clock moved outside a frame");
  a_start_quiet: assert property (s_start |-> cs_n && $past(cs_n, 2) && !wel_o)
    else $error("operation started inside a frame or with latch set");
  a_prog_first_write: assert property (s_start and !erase_req_o |=> mem_we_o)
    else $error("program started without writing");
  a_we_wrap: assert property (mem_we_o && we_reg |->
    mem_addr_o == {addr_reg[23:8], addr_reg[7:0] + 8'h01})
    else $error("write address left its page or skipped");
  a_write_in_busy: assert property (mem_we_o || erase_req_o |-> busy_o)
    else $error("array touched while not busy");
  a_erase_at_start: assert property (erase_req_o |-> s_erase_go)
    else $error("erase request not at busy start");
  a_erase_one_pulse: assert property (erase_req_o |=> !erase_req_o [*8])
    else $error("erase request repeated");
  a_erase_aligned: assert property (erase_req_o |->
    (erase_size_o == 2'h0 && erase_addr_o[11:0] == 12'h000) ||
    (erase_size_o == 2'h1 && erase_addr_o[14:0] == 15'h0000) ||
    (erase_size_o == 2'h2 && erase_addr_o[15:0] == 16'h0000))
    else $error("erase address or size malformed");
  a_fail_flags: assert property (busy_o && fail_i |=> err_o)
    else $error("failure not flagged");
endmodule : sfpe_assertions

// file: bench/spi_flash_program_erase_test.sv
/*
  Self-checking bench: host and device ends joined by the link interface.
  Assumes the design files and sfpe_consts.svh are compiled first.
*/
`timescale 1ns/10ps
`include "sfpe_consts.svh"

module spi_flash_program_erase_test;
  localparam int BP = 300;
  localparam int PP = 400;
  localparam int EC = 120;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic        fail_i = 1'b0;
  logic [7:0]  cmd_op_i = 8'h00;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic [1:0]  cmd_addr_bytes_i = 2'h0;
  logic [9:0]  cmd_data_bytes_i = 10'h000;
  logic [2:0]  cmd_tail_bits_i = 3'h0;
  logic [31:0] prot_i = 32'h00000000;
  logic [7:0]  data_i;
  logic        cmd_ready_o, data_take_o, done_o, busy_o, wel_o, err_o, mem_we_o, erase_req_o;
  logic [23:0] mem_addr_o, erase_addr_o, ea, a;
  logic [7:0]  mem_data_o, sh, nx, w_op, w_b0, op;
  logic [1:0]  erase_size_o, es;
  logic [7:0]  dq [0:1023];
  logic [23:0] wa [0:511];
  logic [7:0]  wd [0:511];
  logic [9:0]  didx = 10'h000;
  logic [31:0] s = 32'hF1CC6D17;
  logic [31:0] r;
  int          nwe, ner, bcnt, nb, n;
  int          fails = 0;
  int          n_compared = 0;
  // Abort cases: short address, no data, stray bits, protected sector
  logic [7:0]  ab_op [7] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h20, 8'h52, 8'hD8};
  logic [1:0]  ab_na [7] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3};
  logic [9:0]  ab_nd [7] = '{10'h1, 10'h0, 10'h2, 10'h1, 10'h0, 10'h0, 10'h0};
  logic [2:0]  ab_tl [7] = '{3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h5, 3'h0};
  logic [7:0]  e_op [3] = '{`SFPE_OP_ERASE_4K, `SFPE_OP_ERASE_32K, `SFPE_OP_ERASE_64K};
  logic [23:0] e_mk [3] = '{`SFPE_MASK_4K, `SFPE_MASK_32K, `SFPE_MASK_64K};

  always #4 ref_clk_i = ~ref_clk_i;
  assign data_i = dq[didx];

  sfpe_link_if link ();
  sfpe_host sfpe_host_i (.ref_clk_i, .nrst_i, .link(link), .cmd_valid_i, .cmd_op_i,
    .cmd_addr_i, .cmd_addr_bytes_i, .cmd_data_bytes_i, .cmd_tail_bits_i, .data_i,
    .cmd_ready_o, .data_take_o, .done_o);
  sfpe_dev #(.BYTE_PROG_CYC(BP), .PAGE_PROG_CYC(PP), .ERASE_CYC(EC)) sfpe_dev_i (.ref_clk_i,
    .nrst_i, .link(link), .prot_i, .fail_i, .busy_o, .wel_o, .err_o, .mem_we_o, .mem_addr_o,
    .mem_data_o, .erase_req_o, .erase_addr_o, .erase_size_o);
  sfpe_assertions sfpe_assertions_i (.ref_clk_i, .nrst_i, .cs_n(link.cs_n), .sck(link.sck),
    .busy_o, .wel_o, .err_o, .fail_i, .mem_we_o, .mem_addr_o, .erase_req_o, .erase_addr_o,
    .erase_size_o);

  // Record array traffic and busy length; advance data source on each take
  always @(posedge ref_clk_i)
  begin
    if (busy_o === 1'b1) bcnt++;
    if (mem_we_o === 1'b1)
    begin
      wa[nwe[8:0]] = mem_addr_o;
      wd[nwe[8:0]] = mem_data_o;
      nwe++;
    end
    if (erase_req_o === 1'b1)
    begin
      ner++;
      ea = erase_addr_o;
      es = erase_size_o;
    end
    if (data_take_o === 1'b1) didx <= didx + 10'h001;
  end

  // Rebuild opcode and first data byte from the wire, two bits per edge when dual
  always @(posedge link.sck)
  if (!link.cs_n)
  begin
    nx = (cmd_op_i == `SFPE_OP_PROG_DUAL && nb >= 32) ? {sh[5:0], link.bio, link.si}
                                                      : {sh[6:0], link.si};
    sh <= nx;
    if (nb == 7) w_op <= nx;
    if (nb == ((cmd_op_i == `SFPE_OP_PROG_DUAL) ? 35 : 39)) w_b0 <= nx;
    nb++;
  end

  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // One frame, then wait for the device to go idle; every wait is bounded
  task automatic run(input logic [7:0] o, input logic [23:0] ad, input logic [1:0] na,
                     input logic [9:0] nd, input logic [2:0] tl);
    int k;
    bit t;
    nwe = 0; ner = 0; bcnt = 0; nb = 0; k = 0;
    cmd_valid_i <= 1'b1; cmd_op_i <= o; cmd_addr_i <= ad; cmd_addr_bytes_i <= na;
    cmd_data_bytes_i <= nd; cmd_tail_bits_i <= tl; didx <= 10'h000;
    do begin @(posedge ref_clk_i); k++; end while (cmd_ready_o !== 1'b1 && k < 50);
    cmd_valid_i <= 1'b0;
    t = (k >= 50);
    k = 0;
    do begin @(posedge ref_clk_i); k++; end while (done_o !== 1'b1 && k < 20000);
    t |= (k >= 20000);
    repeat (6) @(posedge ref_clk_i);
    k = 0;
    while (busy_o !== 1'b0 && k < 1000) begin @(posedge ref_clk_i); k++; end
    t |= (k >= 1000);
    if (t)
    begin
      fails++;
      end_of_test();
    end
    repeat (2) @(posedge ref_clk_i);
  endtask : run

  task wren;
    run(`SFPE_OP_WR_EN, 24'h000000, 2'h0, 10'h000, 3'h0);
    chk("latch set", wel_o, 1);
  endtask : wren

  task automatic prog_check(input logic [23:0] ad, input int cnt);
    int kept, j;
    kept = (cnt > 256) ? 256 : cnt;
    chk("write count", nwe, kept);
    for (int i = 0; i < kept; i++)
    begin
      j = i;
      while (j < cnt - kept) j += 256;
      chk("write addr", wa[i], {ad[23:8], ad[7:0] + i[7:0]});
      chk("write data", wd[i], dq[j]);
    end
    chk("busy length", bcnt, (cnt == 1) ? BP : PP);
    chk("latch after program", wel_o, 0);
    chk("wire opcode", w_op, cmd_op_i);
    chk("wire first byte", w_b0, dq[0]);
  endtask : prog_check

  initial
  begin
    for (int i = 0; i < 1024; i++)
    begin
      r = rnd();
      dq[i] = r[7:0];
    end
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("busy after reset", busy_o, 0);
    chk("latch after reset", wel_o, 0);
    // Program refused with the latch clear
    run(`SFPE_OP_PROG, 24'h000010, 2'h3, 10'h004, 3'h0);
    chk("write count", nwe, 0);
    // Corner programs (wrap at FE, one dual byte, 258 bytes, failure) then random
    for (int t = 0; t < 8; t++)
    begin
      r = rnd();
      op = (t == 1 || t == 3 || (t > 3 && r[31])) ? `SFPE_OP_PROG_DUAL : `SFPE_OP_PROG;
      a = (t == 0) ? {r[23:8], 8'hFE} : r[23:0];
      n = (t == 0) ? 3 : (t == 1) ? 1 : (t == 2) ? 258 : (t == 3) ? 5 : 1 + r[29:24];
      prot_i <= rnd() & ~(32'h1 << a[20:16]);
      fail_i <= (t == 3);
      wren();
      run(op, a, 2'h3, n[9:0], 3'h0);
      prog_check(a, n);
      chk("error flag", err_o, t == 3);
    end
    // All three erase sizes with trailing bytes; the middle one fails
    for (int t = 0; t < 3; t++)
    begin
      r = rnd();
      prot_i <= rnd() & ~(32'h1 << r[20:16]);
      fail_i <= (t == 1);
      wren();
      run(e_op[t], r[23:0], 2'h3, 10'h002, 3'h0);
      chk("erase count", ner, 1);
      chk("erase addr", ea, r[23:0] & e_mk[t]);
      chk("erase size", es, t);
      chk("erase busy", bcnt, EC);
      chk("latch after erase", wel_o, 0);
      chk("error flag", err_o, t == 1);
      chk("write count", nwe, 0);
    end
    fail_i <= 1'b0;
    // Erase refused with the latch clear
    run(`SFPE_OP_ERASE_64K, r[23:0], 2'h3, 10'h000, 3'h0);
    chk("erase count", ner, 0);
    // Aborted frames do nothing and drop the latch
    for (int t = 0; t < 7; t++)
    begin
      r = rnd();
      wren();
      prot_i <= (t == 3 || t == 6) ? (32'h1 << r[20:16]) : 32'h0;
      run(ab_op[t], r[23:0], ab_na[t], ab_nd[t], ab_tl[t]);
      chk("aborted work", nwe + ner + bcnt, 0);
      chk("latch after abort", wel_o, 0);
    end
    end_of_test();
  end
endmodule : spi_flash_program_erase_test
